/* File: src/qsi_status_top.sv */
// Interrupt status, masks, masked status and vectors for channels C/D.
// Assumes datapath events arrive on ref_clk; mode pins are asynchronous.
//
// Overview of operation
// RQ1 - Mode bit 6 picks receive flag meaning
// RQ2 - Ready mode: set on load, re-set after read
// RQ3 - Full mode: set when load fills FIFO
// RQ4 - Full mode: partial FIFO never flags
// RQ5 - Host should drain FIFO in full mode
// RQ6 - Transmit bit copies channel status bit 2
// RQ7 - Transmit ready: cleared on write, set on shift
// RQ8 - Enable sets, disable clears, disabled writes dropped
// RQ9 - Timer: set per wave, stop clears only
// RQ10 - Counter: set at terminal, stop clears, halts
// RQ11 - Break C change sticky until reset command
// RQ12 - Status C/D bit layout fixed
// RQ13 - Mask bit one enables, zero masks
// RQ14 - Mask A/B bit layout fixed
// RQ15 - Mask registers read back as zero
// RQ16 - Status sets regardless of mask
// RQ17 - Masked status is status AND mask
// RQ18 - Vectors active in 68 or vectored mode
// RQ19 - Otherwise vectors are plain storage
// RQ20 - No interrupts for parity, overrun, framing
// RQ21 - Host should poll channel error nibble
// RQ22 - Input change sets bit 7, read clears
// RQ23 - Break D change sticky until reset command
// RQ24 - Open-drain active-low interrupt request
// RQ25 - Request while any masked bit set
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module qsi_status_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire qsi_pkg::qsi_addr_t regAddr,
    input wire qsi_pkg::qsi_byte_t regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output qsi_pkg::qsi_byte_t regRdata_r,
    // Mode pins
    input wire logic busMode68Pin,
    input wire logic vectoredPin,
    // Channel C/D events, index 0 is C
    input wire qsi_pkg::qsi_rx_s [1:0] rxEv,
    input wire qsi_pkg::qsi_tx_s [1:0] txEv,
    input wire logic [1:0] breakEdge,
    // Input change and counter 2
    input wire logic inChange,
    input wire qsi_pkg::qsi_byte_t inChangeData,
    input wire logic ctrEvent,
    input wire logic ctrTimerMode,
    // Channel A/B status from outside
    input wire qsi_pkg::qsi_byte_t statusAb,
    // Interrupt pin
    output logic irqOutN_r,
    output logic irqOe_r,
    // Channel and counter side
    output logic [1:0] txReady,
    output logic [1:0] txAccept_r,
    output logic ctrHalt_r,
    // Vector side
    output logic vecEnable_r,
    output qsi_pkg::qsi_byte_t vecOut_r
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    qsi_pkg::qsi_byte_t maskAb_r;
    qsi_pkg::qsi_byte_t maskCd_r;
    qsi_pkg::qsi_byte_t vecAb_r;
    qsi_pkg::qsi_byte_t vecCd_r;
    qsi_pkg::qsi_byte_t modeC_r;
    qsi_pkg::qsi_byte_t modeD_r;
    logic inChg_r;
    logic ctrRdy_r;
    logic [1:0] brk_r;
    logic [1:0] modeSyncA_r;
    logic [1:0] modeSyncB_r;
    logic [1:0] rxFlag;
    logic [1:0] txAcc;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire wrMaskAb = regWr && regAddr == qsi_pkg::OFS_MASK_AB;
    wire wrMaskCd = regWr && regAddr == qsi_pkg::OFS_MASK_CD;
    wire wrVecAb = regWr && regAddr == qsi_pkg::OFS_VEC_AB;
    wire wrVecCd = regWr && regAddr == qsi_pkg::OFS_VEC_CD;
    wire wrModeC = regWr && regAddr == qsi_pkg::OFS_MODE_C;
    wire wrModeD = regWr && regAddr == qsi_pkg::OFS_MODE_D;
    wire wrCmd = regWr && regAddr == qsi_pkg::OFS_CMD;
    wire rdInChg = regRd && regAddr == qsi_pkg::OFS_INCHG;
    wire clrBrkC = wrCmd && regWdata[qsi_pkg::CMD_BRK_C];
    wire clrBrkD = wrCmd && regWdata[qsi_pkg::CMD_BRK_D];
    wire stopCmd = wrCmd && regWdata[qsi_pkg::CMD_STOP_CTR];
    wire [1:0] clrBrk = {clrBrkD, clrBrkC};

    // ----------------------------------------
    // Per-channel flags
    // ----------------------------------------
    wire [1:0] fullMode = {modeD_r[qsi_pkg::BIT_MODE_FULL], modeC_r[qsi_pkg::BIT_MODE_FULL]}; // see RQ1

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            qsi_rx_flag u_rx (
                .clk(ref_clk),
                .rst(rst),
                .fullMode(fullMode[ch]),
                .ev(rxEv[ch]),
                .flag_r(rxFlag[ch])
            );
            qsi_tx_ready u_tx (
                .clk(ref_clk),
                .rst(rst),
                .ev(txEv[ch]),
                .ready_r(txReady[ch]),
                .accept(txAcc[ch])
            );
            // Break change is the only receive error that flags
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    brk_r[ch] <= 1'b0;
                end else if (breakEdge[ch]) begin
                    brk_r[ch] <= 1'b1; // see RQ11, see RQ23, see RQ20
                end else if (clrBrk[ch]) begin
                    brk_r[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Status assembly and masking
    // ----------------------------------------
    qsi_pkg::qsi_byte_t statCd;
    always_comb begin
        statCd = 8'h00;
        statCd[qsi_pkg::BIT_INCHG] = inChg_r; // see RQ12
        statCd[qsi_pkg::BIT_BRK_D] = brk_r[1];
        statCd[qsi_pkg::BIT_RX_D] = rxFlag[1];
        statCd[qsi_pkg::BIT_TX_D] = txReady[1]; // see RQ6
        statCd[qsi_pkg::BIT_CTR] = ctrRdy_r;
        statCd[qsi_pkg::BIT_BRK_C] = brk_r[0];
        statCd[qsi_pkg::BIT_RX_C] = rxFlag[0];
        statCd[qsi_pkg::BIT_TX_C] = txReady[0]; // see RQ6
    end

    // A/B layout is input change 7 down to A transmit 0
    wire [7:0] mstatAb = statusAb & maskAb_r; // see RQ13, see RQ14, see RQ17
    wire [7:0] mstatCd = statCd & maskCd_r; // see RQ13, see RQ17
    wire anyMasked = (|mstatAb) || (|mstatCd);
    wire vecMode = modeSyncB_r[0] || modeSyncB_r[1];

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire [7:0] rdData =
        (regAddr == qsi_pkg::OFS_STAT_CD) ? statCd :
        (regAddr == qsi_pkg::OFS_MSTAT_AB) ? mstatAb :
        (regAddr == qsi_pkg::OFS_MSTAT_CD) ? mstatCd :
        (regAddr == qsi_pkg::OFS_VEC_AB) ? vecAb_r :
        (regAddr == qsi_pkg::OFS_VEC_CD) ? vecCd_r :
        (regAddr == qsi_pkg::OFS_MODE_C) ? modeC_r :
        (regAddr == qsi_pkg::OFS_MODE_D) ? modeD_r :
        (regAddr == qsi_pkg::OFS_INCHG) ? inChangeData :
        qsi_pkg::RD_IDLE; // see RQ15

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdata_r <= qsi_pkg::RD_IDLE;
        end else begin
            regRdata_r <= regRd ? rdData : qsi_pkg::RD_IDLE;
        end
    end

    // ----------------------------------------
    // Writable registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            maskAb_r <= qsi_pkg::MASK_RESET;
            maskCd_r <= qsi_pkg::MASK_RESET;
            vecAb_r <= qsi_pkg::VEC_RESET;
            vecCd_r <= qsi_pkg::VEC_RESET;
            modeC_r <= qsi_pkg::MODE_RESET;
            modeD_r <= qsi_pkg::MODE_RESET;
        end else begin
            if (wrMaskAb) maskAb_r <= regWdata;
            if (wrMaskCd) maskCd_r <= regWdata;
            if (wrVecAb) vecAb_r <= regWdata; // see RQ19
            if (wrVecCd) vecCd_r <= regWdata; // see RQ19
            if (wrModeC) modeC_r <= regWdata;
            if (wrModeD) modeD_r <= regWdata;
        end
    end

    // ----------------------------------------
    // Input change and counter flags
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inChg_r <= 1'b0;
            ctrRdy_r <= 1'b0;
            ctrHalt_r <= 1'b0;
        end else begin
            inChg_r <= inChange || (inChg_r && !rdInChg); // see RQ22, see RQ16
            ctrRdy_r <= ctrEvent || (ctrRdy_r && !stopCmd); // see RQ9, see RQ10
            ctrHalt_r <= stopCmd && !ctrTimerMode; // see RQ10
        end
    end

    // ----------------------------------------
    // Interrupt pin and vector
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            modeSyncA_r <= 2'b00;
            modeSyncB_r <= 2'b00;
            irqOutN_r <= 1'b0;
            irqOe_r <= 1'b0;
            txAccept_r <= 2'b00;
            vecEnable_r <= 1'b0;
            vecOut_r <= qsi_pkg::VEC_RESET;
        end else begin
            modeSyncA_r <= {vectoredPin, busMode68Pin};
            modeSyncB_r <= modeSyncA_r;
            irqOutN_r <= 1'b0; // see RQ24
            irqOe_r <= anyMasked; // see RQ25
            txAccept_r <= txAcc;
            vecEnable_r <= vecMode; // see RQ18
            vecOut_r <= (|mstatAb) ? vecAb_r : vecCd_r;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_irq_follows: assert property (anyMasked |=> irqOe_r && !irqOutN_r) // see RQ25
        else $error("irq enable does not follow masked status");
    a_irq_release: assert property (!anyMasked |=> !irqOe_r) // see RQ24
        else $error("irq not released");
    a_mstat_and: assert property (regRd && regAddr == qsi_pkg::OFS_MSTAT_CD |=> // see RQ17
        regRdata_r == $past(statCd & maskCd_r))
        else $error("masked status read wrong");
    a_mask_wo: assert property (regRd && (regAddr == qsi_pkg::OFS_MASK_AB || // see RQ15
        regAddr == qsi_pkg::OFS_MASK_CD) |=> regRdata_r == 8'h00)
        else $error("mask register read back");
    a_brk_set: assert property (breakEdge[0] |=> statCd[qsi_pkg::BIT_BRK_C]) // see RQ11
        else $error("break C change not set");
    a_brk_hold: assert property (brk_r[1] && !clrBrkD |=> brk_r[1]) // see RQ23
        else $error("break D change lost");
    a_ctr_halt: assert property (stopCmd |=> ctrHalt_r == !$past(ctrTimerMode) && !ctrRdy_r || // see RQ9
        $past(ctrEvent))
        else $error("stop command effect wrong");
    a_ctr_set: assert property (ctrEvent |=> statCd[qsi_pkg::BIT_CTR]) // see RQ10
        else $error("counter ready not set");
    a_inchg_set: assert property (inChange && maskCd_r == 8'h00 |=> statCd[qsi_pkg::BIT_INCHG]) // see RQ16
        else $error("input change not set while masked");
    a_tx_copy: assert property (regRd && regAddr == qsi_pkg::OFS_STAT_CD |=> // see RQ6
        regRdata_r[qsi_pkg::BIT_TX_D] == $past(txReady[1]) &&
        regRdata_r[qsi_pkg::BIT_TX_C] == $past(txReady[0]))
        else $error("transmit bit not a copy");
    a_rx_partial: assert property (fullMode[1] && !rxFlag[1] && rxEv[1].load && !rxEv[1].full |=> // see RQ4
        !rxFlag[1])
        else $error("full mode flag set on partial FIFO");
    a_vec_mode: assert property (vecEnable_r == $past(busMode68Pin || vectoredPin, 3)) // see RQ18
        else $error("vector enable wrong");
    a_rx_ready_pop: assert property (!fullMode[0] && rxEv[0].pop && !rxEv[0].load && // see RQ2
        !$past(rxEv[0].pop) |=> !rxFlag[0])
        else $error("ready flag not cleared by read");
    a_rx_full_set: assert property (fullMode[1] && rxEv[1].load && rxEv[1].full |=> rxFlag[1]) // see RQ3
        else $error("full flag not set when FIFO fills");
    a_tx_write: assert property (txEv[0].enable && $past(txEv[0].enable) && txEv[0].write && // see RQ7
        !txEv[0].shiftLoad |=> !txReady[0])
        else $error("transmit ready not cleared by write");
    a_tx_disable: assert property (!txEv[1].enable |=> !txReady[1]) // see RQ8
        else $error("transmit ready set while disabled");
    a_brk_clear: assert property (clrBrkC && !breakEdge[0] |=> !brk_r[0]) // see RQ11
        else $error("break C change not cleared");
    a_inchg_clear: assert property (rdInChg && !inChange |=> !inChg_r) // see RQ22
        else $error("input change not cleared by read");
    a_stat_read: assert property (regRd && regAddr == qsi_pkg::OFS_STAT_CD |=> // see RQ12
        regRdata_r == $past(statCd))
        else $error("status read wrong");
    a_mstat_ab: assert property (regRd && regAddr == qsi_pkg::OFS_MSTAT_AB |=> // see RQ14
        regRdata_r == $past(statusAb & maskAb_r))
        else $error("masked status A/B read wrong");
    a_vec_pick: assert property ((|mstatAb) |=> vecOut_r == $past(vecAb_r)) // see RQ18
        else $error("vector A/B not selected");

    c_irq_rise: cover property (!irqOe_r ##1 irqOe_r);
    c_stop_counter: cover property (stopCmd && !ctrTimerMode ##1 ctrHalt_r);
    c_rx_full: cover property (fullMode[1] && rxEv[1].load && rxEv[1].full ##1 rxFlag[1]);
    c_vec_read: cover property (vecEnable_r && irqOe_r);
endmodule

/* File: src/qsi_pkg.sv */
// Constants, offsets and carrier types for the C/D interrupt status block.
// Assumes one clock domain; every event struct field is driven on ref_clk.
package qsi_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    typedef logic [ADDR_W-1:0] qsi_addr_t;
    typedef logic [DATA_W-1:0] qsi_byte_t;
    localparam qsi_addr_t OFS_STAT_CD = 4'h0;
    localparam qsi_addr_t OFS_MASK_AB = 4'h1;
    localparam qsi_addr_t OFS_MASK_CD = 4'h2;
    localparam qsi_addr_t OFS_MSTAT_AB = 4'h3;
    localparam qsi_addr_t OFS_MSTAT_CD = 4'h4;
    localparam qsi_addr_t OFS_VEC_AB = 4'h5;
    localparam qsi_addr_t OFS_VEC_CD = 4'h6;
    localparam qsi_addr_t OFS_CMD = 4'h7;
    localparam qsi_addr_t OFS_MODE_C = 4'h8;
    localparam qsi_addr_t OFS_MODE_D = 4'h9;
    localparam qsi_addr_t OFS_INCHG = 4'hA;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_INCHG = 7;
    localparam int BIT_BRK_D = 6;
    localparam int BIT_RX_D = 5;
    localparam int BIT_TX_D = 4;
    localparam int BIT_CTR = 3;
    localparam int BIT_BRK_C = 2;
    localparam int BIT_RX_C = 1;
    localparam int BIT_TX_C = 0;
    localparam int BIT_MODE_FULL = 6;
    localparam int CMD_BRK_C = 0;
    localparam int CMD_BRK_D = 1;
    localparam int CMD_STOP_CTR = 2;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam qsi_byte_t MASK_RESET = 8'h00;
    localparam qsi_byte_t VEC_RESET = 8'h0F;
    localparam qsi_byte_t MODE_RESET = 8'h00;
    localparam qsi_byte_t RD_IDLE = 8'h00;
    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic load;
        logic pop;
        logic full;
        logic notEmpty;
    } qsi_rx_s;
    typedef struct packed {
        logic enable;
        logic write;
        logic shiftLoad;
    } qsi_tx_s;
endpackage

/* File: src/qsi_rx_flag.sv */
// Receive status flag of one channel, ready or FIFO-full meaning.
// Assumes FIFO level inputs show the state after this cycle's transfer.
`timescale 1ns/1ps
module qsi_rx_flag (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control and events
    input wire logic fullMode,
    input wire qsi_pkg::qsi_rx_s ev,
    // Flag
    output logic flag_r
);
    logic popDly_r;
    wire readySet = ev.load || (popDly_r && ev.notEmpty); // see RQ2
    wire fullSet = ev.load && ev.full; // see RQ3, see RQ4
    wire setEv = fullMode ? fullSet : readySet; // see RQ1
    wire flag_nxt = setEv ? 1'b1 : (ev.pop ? 1'b0 : flag_r);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_r <= 1'b0;
            popDly_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            popDly_r <= ev.pop;
        end
    end
endmodule

/* File: src/qsi_tx_ready.sv */
// Transmit-ready bit of one channel, also its status bit 2 copy.
// Assumes write and shiftLoad are one-cycle pulses on clk.
`timescale 1ns/1ps
module qsi_tx_ready (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Events
    input wire qsi_pkg::qsi_tx_s ev,
    // State
    output logic ready_r,
    output logic accept
);
    logic enDly_r;
    wire enRise = ev.enable && !enDly_r;
    assign accept = ev.write && ev.enable; // see RQ8
    wire ready_nxt = !ev.enable ? 1'b0 :
                     (enRise || ev.shiftLoad) ? 1'b1 :
                     accept ? 1'b0 : ready_r; // see RQ7, see RQ8

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_r <= 1'b0;
            enDly_r <= 1'b0;
        end else begin
            ready_r <= ready_nxt;
            enDly_r <= ev.enable;
        end
    end
endmodule

/* File: sim/qsi_host_model.sv */
// Host model: register bus master and the pulled-up interrupt line.
// Assumes the device samples strobes on the rising edge of clk.
`timescale 1ns/1ps
module qsi_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output qsi_pkg::qsi_addr_t regAddr,
    output qsi_pkg::qsi_byte_t regWdata,
    output logic regWr,
    output logic regRd,
    input wire qsi_pkg::qsi_byte_t regRdata_r,
    // Interrupt pin
    input wire logic irqOutN_r,
    input wire logic irqOe_r,
    output logic irqLine
);
    // Open-drain line, pull-up while released
    assign irqLine = irqOe_r ? irqOutN_r : 1'b1;
    initial begin
        regAddr = 4'h0;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    // Idle bus shows inverted values, not stale ones
    task automatic wr(input qsi_pkg::qsi_addr_t a, input qsi_pkg::qsi_byte_t v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWr <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~v;
    endtask
    task automatic rd(input qsi_pkg::qsi_addr_t a, output qsi_pkg::qsi_byte_t v);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        regAddr <= ~a;
        #1 v = regRdata_r;
    endtask
endmodule

/* File: sim/qsi_testbench.sv */
// Self-checking bench for the C/D interrupt status block.
// Assumes the host model drives the register port on ref_clk.
`timescale 1ns/1ps
module testbench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam qsi_pkg::qsi_addr_t ST = qsi_pkg::OFS_STAT_CD;
    localparam qsi_pkg::qsi_addr_t MC = qsi_pkg::OFS_MSTAT_CD;
    localparam qsi_pkg::qsi_addr_t CM = qsi_pkg::OFS_CMD;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic busMode68Pin = 1'b0;
    logic vectoredPin = 1'b0;
    qsi_pkg::qsi_rx_s [1:0] rxEv = 8'h00;
    qsi_pkg::qsi_tx_s [1:0] txEv = 6'h00;
    logic [1:0] breakEdge = 2'h0;
    logic inChange = 1'b0;
    logic ctrEvent = 1'b0;
    logic ctrTimerMode = 1'b0;
    qsi_pkg::qsi_byte_t statusAb = 8'h00;
    qsi_pkg::qsi_addr_t regAddr;
    qsi_pkg::qsi_byte_t regWdata, regRdata_r, vecOut_r, d;
    logic regWr, regRd, irqOutN_r, irqOe_r, irqLine, ctrHalt_r, vecEnable_r;
    logic [1:0] txReady, txAccept_r;
    int miscompares = 0;
    int total_checks = 0;
    int acc = 0;
    int halts = 0;
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (txAccept_r[0] === 1'b1) acc++;
        if (ctrHalt_r === 1'b1) halts++;
    end
    qsi_host_model u_qsi_host_model (.clk(ref_clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata_r(regRdata_r), .irqOutN_r(irqOutN_r), .irqOe_r(irqOe_r), .irqLine(irqLine));
    qsi_status_top u_qsi_status_top (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r), .busMode68Pin(busMode68Pin),
        .vectoredPin(vectoredPin), .rxEv(rxEv), .txEv(txEv), .breakEdge(breakEdge), .inChange(inChange),
        .inChangeData(8'h3C), .ctrEvent(ctrEvent), .ctrTimerMode(ctrTimerMode), .statusAb(statusAb),
        .irqOutN_r(irqOutN_r), .irqOe_r(irqOe_r), .txReady(txReady), .txAccept_r(txAccept_r),
        .ctrHalt_r(ctrHalt_r), .vecEnable_r(vecEnable_r), .vecOut_r(vecOut_r));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(string n, qsi_pkg::qsi_byte_t s, qsi_pkg::qsi_byte_t e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rc(string n, qsi_pkg::qsi_addr_t a, qsi_pkg::qsi_byte_t e);
        u_qsi_host_model.rd(a, d);
        chk(n, d, e);
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic rxev(int c, logic ld, logic fl, logic ne);
        @(posedge ref_clk);
        rxEv[c].load <= ld;
        rxEv[c].pop <= !ld;
        rxEv[c].full <= fl;
        rxEv[c].notEmpty <= ne;
        @(posedge ref_clk);
        rxEv[c].load <= 1'b0;
        rxEv[c].pop <= 1'b0;
        tick(2);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rc("vec rst", qsi_pkg::OFS_VEC_CD, qsi_pkg::VEC_RESET);
        u_qsi_host_model.wr(qsi_pkg::OFS_MASK_CD, 8'hFF);
        rc("mask cd", qsi_pkg::OFS_MASK_CD, qsi_pkg::RD_IDLE);
        rc("mask ab", qsi_pkg::OFS_MASK_AB, qsi_pkg::RD_IDLE);
        chk("irq idle", irqLine, 1'b1);
        u_qsi_host_model.wr(qsi_pkg::OFS_MASK_CD, 8'h00);
        rc("unmapped", 4'hF, qsi_pkg::RD_IDLE);
    endtask
    task automatic t_brk();
        qsi_pkg::qsi_byte_t m;
        for (int i = 0; i < 2; i++) begin
            m = (i == 0) ? 8'h04 : 8'h40;
            @(posedge ref_clk);
            breakEdge[i] <= 1'b1;
            @(posedge ref_clk);
            breakEdge[i] <= 1'b0;
            rc("brk", ST, m);
            rc("brk masked", MC, 8'h00);
            chk("irq off", irqLine, 1'b1);
            u_qsi_host_model.wr(qsi_pkg::OFS_MASK_CD, m);
            tick(2);
            chk("irq on", irqLine, 1'b0);
            rc("brk on", MC, m);
            u_qsi_host_model.wr(CM, (i == 0) ? 8'h02 : 8'h01);
            rc("other cmd", ST, m);
            u_qsi_host_model.wr(CM, (i == 0) ? 8'h01 : 8'h02);
            tick(2);
            rc("brk clr", ST, 8'h00);
            chk("irq clr", irqLine, 1'b1);
            u_qsi_host_model.wr(qsi_pkg::OFS_MASK_CD, 8'h00);
        end
    endtask
    task automatic t_rx();
        rxev(0, 1'b1, 1'b0, 1'b1);
        rc("rdy set", ST, 8'h02);
        rxev(0, 1'b0, 1'b0, 1'b1);
        rc("rdy again", ST, 8'h02);
        rxev(0, 1'b0, 1'b0, 1'b0);
        rc("rdy clr", ST, 8'h00);
        u_qsi_host_model.wr(qsi_pkg::OFS_MODE_D, 8'h40);
        rxev(1, 1'b1, 1'b0, 1'b1);
        rxev(1, 1'b1, 1'b0, 1'b1);
        rc("partial", ST, 8'h00);
        rxev(1, 1'b1, 1'b1, 1'b1);
        rc("full", ST, 8'h20);
        rxev(1, 1'b0, 1'b0, 1'b1);
        rc("full pop", ST, 8'h00);
        rxev(1, 1'b1, 1'b1, 1'b1);
        rc("refill", ST, 8'h20);
        rxev(1, 1'b0, 1'b0, 1'b0);
        rc("drained", ST, 8'h00);
    endtask
    task automatic t_tx();
        @(posedge ref_clk);
        txEv[0].write <= 1'b1;
        @(posedge ref_clk);
        txEv[0].write <= 1'b0;
        txEv[0].enable <= 1'b1;
        txEv[1].enable <= 1'b1;
        tick(3);
        chk("dropped", 8'(acc), 8'h00);
        chk("tx en", txReady, 2'h3);
        rc("tx bits", ST, 8'h11);
        @(posedge ref_clk);
        txEv[0].write <= 1'b1;
        @(posedge ref_clk);
        txEv[0].write <= 1'b0;
        tick(2);
        chk("accept", 8'(acc), 8'h01);
        rc("tx wr", ST, 8'h10);
        @(posedge ref_clk);
        txEv[0].shiftLoad <= 1'b1;
        @(posedge ref_clk);
        txEv[0].shiftLoad <= 1'b0;
        tick(1);
        chk("tx shift", txReady, 2'h3);
        txEv <= 6'h00;
        tick(2);
        chk("tx dis", txReady, 2'h0);
    endtask
    task automatic t_ctr();
        int h;
        for (int md = 0; md < 2; md++) begin
            ctrTimerMode <= (md == 1);
            @(posedge ref_clk);
            ctrEvent <= 1'b1;
            @(posedge ref_clk);
            ctrEvent <= 1'b0;
            rc("ctr set", ST, 8'h08);
            h = halts;
            u_qsi_host_model.wr(CM, 8'h04);
            tick(2);
            rc("ctr stop", ST, 8'h00);
            chk("halt", 8'(halts - h), (md == 0) ? 8'h01 : 8'h00);
        end
    endtask
    task automatic t_inc();
        @(posedge ref_clk);
        inChange <= 1'b1;
        @(posedge ref_clk);
        inChange <= 1'b0;
        rc("inchg", ST, 8'h80);
        rc("inchg data", qsi_pkg::OFS_INCHG, 8'h3C);
        rc("inchg clr", ST, 8'h00);
    endtask
    task automatic t_vec();
        u_qsi_host_model.wr(qsi_pkg::OFS_VEC_AB, 8'h5A);
        u_qsi_host_model.wr(qsi_pkg::OFS_VEC_CD, 8'hA5);
        rc("vec ab", qsi_pkg::OFS_VEC_AB, 8'h5A);
        rc("vec cd", qsi_pkg::OFS_VEC_CD, 8'hA5);
        chk("vec off", vecEnable_r, 1'b0);
        busMode68Pin <= 1'b1;
        tick(4);
        chk("vec 68", vecEnable_r, 1'b1);
        busMode68Pin <= 1'b0;
        vectoredPin <= 1'b1;
        tick(4);
        chk("vec sub", vecEnable_r, 1'b1);
        statusAb <= 8'h88;
        u_qsi_host_model.wr(qsi_pkg::OFS_MASK_AB, 8'h80);
        tick(2);
        rc("mstat ab", qsi_pkg::OFS_MSTAT_AB, 8'h80);
        chk("vec pick ab", vecOut_r, 8'h5A);
        chk("irq ab", irqLine, 1'b0);
        vectoredPin <= 1'b0;
        u_qsi_host_model.wr(qsi_pkg::OFS_MASK_AB, 8'h77);
        tick(2);
        rc("mstat ab off", qsi_pkg::OFS_MSTAT_AB, 8'h00);
        chk("vec pick cd", vecOut_r, 8'hA5);
        chk("vec none", vecEnable_r, 1'b0);
    endtask
    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial begin
        tick(2);
        rst <= 1'b0;
        tick(3);
        t_regs();
        t_brk();
        t_rx();
        t_tx();
        t_ctr();
        t_inc();
        t_vec();
        complete_run();
    end
    initial begin
        tick(20000);
        miscompares++;
        complete_run();
    end
endmodule
